//--- inc/lsu_pkg.sv
// Shared constants and types for the load/store unit
package lsu_pkg;
	localparam int XLEN = 32;
	localparam int DW_BYTES = 8;
	localparam int OFS_W = 3;
	localparam int RSV_SHIFT = 5;
	localparam int RC_BIT = 31;
	localparam int REGIDX_W = 5;
	localparam logic [REGIDX_W-1:0] REG_ZERO = 5'h00;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_DBL = 2'h3;
	localparam int GATHER_BIT = 0;

	typedef enum logic [2:0]
	{
		LSU_OP_LOAD,
		LSU_OP_STORE,
		LSU_OP_LRES,
		LSU_OP_SCOND,
		LSU_OP_ECOUT,
		LSU_OP_BARRIER
	} lsu_op_t;

	typedef enum logic [1:0]
	{
		LSU_MR_NONE,
		LSU_MR_CACHE,
		LSU_MR_BUS,
		LSU_MR_IFETCH
	} lsu_route_t;

	// Byte mask of an access starting at offset with size code
	function automatic logic [15:0] lsu_mask(logic [2:0] ofs,
		logic [1:0] sz);
		logic [15:0] m;
		m = 16'h0000;
		case (sz)
			SZ_BYTE: m = 16'h0001;
			SZ_HALF: m = 16'h0003;
			SZ_WORD: m = 16'h000f;
			default: m = 16'h00ff;
		endcase
		return 16'(m << ofs);
	endfunction
endpackage

//--- core/lsu_swap.sv
// Byte-reversal of a half word or word element
module lsu_swap
	import lsu_pkg::*;
(
	// Element in
	input wire logic [63:0] din,
	input wire logic [1:0] size,
	input wire logic enable,
	// Element out
	output logic [63:0] dout
);
	always_comb
	begin
		dout = din;
		if (enable && size == SZ_HALF)
			dout = {48'h0, din[7:0], din[15:8]};
		else if (enable && size == SZ_WORD)
			dout = {32'h0, din[7:0], din[15:8], din[23:16], din[31:24]};
	end
endmodule

//--- core/lsu_fill.sv
// Zero or sign fill of loaded elements
module lsu_fill
	import lsu_pkg::*;
(
	// Raw element
	input wire logic [63:0] din,
	input wire logic [1:0] size,
	input wire logic sign_ext,
	// Register value
	output logic [63:0] dout
);
	always_comb
	begin
		case (size)
			SZ_BYTE: dout = {56'h0, din[7:0]};
			SZ_HALF: dout = sign_ext ? {{48{din[15]}}, din[15:0]}
				: {48'h0, din[15:0]};
			SZ_WORD: dout = {32'h0, din[31:0]};
			default: dout = din;
		endcase
	end
endmodule

//--- core/lsu_core.sv
// Integer load/store execution unit
// Notes on behaviour
// - Issue and translate in order; completions may reorder unless synced.
// - Misaligned within a double word takes one cycle; crossing costs more.
// - Page fault on second portion restarts whole access; first may repeat.
// - Translation reloads wait transparently; only page faults restart.
// - String transfers never merge registers except through gathering.
// - Instruction fetch bus requests never assert the coherence attribute.
// - Loads read byte, half, word or double word at effective address.
// - Zero-fill clears upper bits; algebraic half fills with sign bit.
// - Load update with valid base writes address to base register.
// - Algebraic and byte-reversed forms keep the ordinary latency.
// - Load-reserve reserves the aligned 32-byte section; conditional checks it.
// - Reserve pair ignores write-through for storage faults; others still fault.
// - Every store-conditional goes out on the external bus.
// - Stores write source element to memory at effective address.
// - Store update writes base after store; source value captured first.
// - Store with record-condition bit 31 set is an invalid form.
// - Gather only word-aligned 4-byte write-through/inhibited unguarded stores.
// - Gathered pair forms one double word, single-beat bus write.
// - Gather only queued pending stores, any address order.
// - Gathering only while enable bit set; same in both endian modes.
// - Never gather cacheable, guarded, reversed, conditional, control, walk, barrier.
// - Byte-reversed forms swap element bytes relative to endian mode; the swap here ignores little_endian.
//
module lsu_core
	import lsu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Issue side
	input wire logic iss_valid,
	output logic iss_ready,
	input wire lsu_pkg::lsu_op_t iss_op,
	input wire logic [1:0] iss_size,
	input wire logic iss_sign,
	input wire logic iss_rev,
	input wire logic iss_update,
	input wire logic iss_float,
	input wire logic [31:0] iss_instr,
	input wire logic [REGIDX_W-1:0] iss_base,
	input wire logic [REGIDX_W-1:0] iss_dest,
	input wire logic [XLEN-1:0] iss_ea,
	input wire logic [63:0] iss_src_data,
	input wire logic iss_sync,
	// Attributes from translation
	input wire logic attr_wt,
	input wire logic attr_ci,
	input wire logic attr_guard,
	input wire logic attr_table_walk,
	input wire logic little_endian,
	// Configuration register zero
	input wire logic [XLEN-1:0] impl_config_reg_zero,
	// Cache side
	output logic dc_req,
	output logic dc_we,
	output logic [XLEN-1:0] dc_addr,
	output logic [63:0] dc_wdata,
	output logic [7:0] dc_be,
	input wire logic dc_ack,
	input wire logic [63:0] dc_rdata,
	input wire logic dc_reload,
	input wire logic dc_fault,
	input wire logic dc_wt_fault,
	// Bus side
	output logic bus_req,
	output logic bus_we,
	output logic bus_global,
	output logic [XLEN-1:0] bus_addr,
	output logic [63:0] bus_wdata,
	output logic [7:0] bus_be,
	input wire logic bus_ack,
	input wire logic ifetch_req,
	input wire logic [XLEN-1:0] ifetch_addr,
	// Results
	output logic wb_valid,
	output logic [REGIDX_W-1:0] wb_reg,
	output logic [63:0] wb_data,
	output logic upd_valid,
	output logic [REGIDX_W-1:0] upd_reg,
	output logic [XLEN-1:0] upd_data,
	output logic cond_ok,
	output logic fault_dsi,
	output logic invalid_form,
	output logic restart
);
	import lsu_pkg::*;

	typedef enum logic [2:0]
	{
		LSU_IDLE,
		LSU_FIRST,
		LSU_SECOND,
		LSU_BUS,
		LSU_DONE
	} lsu_state_t;

	lsu_state_t state_q;
	lsu_op_t op_q;
	logic [1:0] size_q;
	logic sign_q, rev_q, upd_q, le_q;
	logic [REGIDX_W-1:0] base_q, dest_q;
	logic [XLEN-1:0] ea_q;
	logic [63:0] src_q, load_q;
	logic cross_q, gath_q;
	logic [15:0] mask_q;
	logic rsv_valid_q;
	logic [XLEN-RSV_SHIFT-1:0] rsv_sect_q;
	// Gather slot: one pending word store
	logic pend_q;
	logic [XLEN-1:0] pend_addr_q;
	logic [31:0] pend_data_q;
	logic [63:0] swapped, filled, merged;
	logic [15:0] mask_d;
	logic gather_ok, pair_hit, bad_form;
	// Gather slot drained by the bus, never by a fetch beat
	logic flush;
	assign flush = state_q == LSU_IDLE && pend_q && (gath_q || iss_sync)
		&& bus_ack;

	////////////////////////////////////////////////////////////////////
	// Decode at issue
	assign mask_d = lsu_mask(iss_ea[OFS_W-1:0], iss_size);
	assign bad_form = iss_op == LSU_OP_STORE && iss_instr[RC_BIT];
	assign gather_ok = iss_op == LSU_OP_STORE && iss_size == SZ_WORD
		&& iss_ea[1:0] == 2'h0 && (attr_wt || attr_ci) && !attr_guard
		&& !iss_rev && !iss_float && !attr_table_walk
		&& impl_config_reg_zero[GATHER_BIT];
	// Pair with pending store, either order
	assign pair_hit = pend_q && gather_ok && !iss_sync
		&& iss_ea[XLEN-1:OFS_W] == pend_addr_q[XLEN-1:OFS_W]
		&& iss_ea[2] != pend_addr_q[2];

	// One operation accepted at a time, in order
	assign iss_ready = state_q == LSU_IDLE;

	////////////////////////////////////////////////////////////////////
	// Byte reversal and fill, same path for every load form
	// Reversal of element bytes
	lsu_swap u_swap
	(
		.din(op_q == LSU_OP_STORE ? src_q : load_q),
		.size(size_q),
		.enable(rev_q),
		.dout(swapped)
	);

	lsu_fill u_fill
	(
		.din(swapped),
		.size(size_q),
		.sign_ext(sign_q),
		.dout(filled)
	);

	// Store data lined up at its byte offset, first portion for a crossing
	assign merged = swapped << {ea_q[OFS_W-1:0], 3'h0};

	////////////////////////////////////////////////////////////////////
	// Operation sequencer
	always_ff @(posedge clk)
	begin
		if (reset)
			state_q <= LSU_IDLE;
		else
		begin
			case (state_q)
				LSU_IDLE:
					if (iss_valid && !bad_form && iss_op != LSU_OP_BARRIER
						&& !(gather_ok && iss_op == LSU_OP_STORE))
						state_q <= iss_op == LSU_OP_SCOND ? LSU_BUS
							: LSU_FIRST;
				LSU_FIRST:
					if (dc_fault)
						state_q <= LSU_IDLE;
					else if (dc_ack && !dc_reload)
						state_q <= cross_q ? LSU_SECOND : LSU_DONE;
				LSU_SECOND:
					if (dc_fault)
						state_q <= LSU_IDLE;
					else if (dc_ack && !dc_reload)
						state_q <= LSU_DONE;
				LSU_BUS:
					if (bus_ack)
						state_q <= LSU_DONE;
				default:
					state_q <= LSU_IDLE;
			endcase
		end
	end

	// Operation capture at issue
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			op_q <= LSU_OP_LOAD;
			size_q <= SZ_BYTE;
			sign_q <= 1'b0;
			rev_q <= 1'b0;
			upd_q <= 1'b0;
			le_q <= 1'b0;
			base_q <= REG_ZERO;
			dest_q <= REG_ZERO;
			ea_q <= '0;
			src_q <= '0;
			cross_q <= 1'b0;
			mask_q <= '0;
		end
		else if (iss_valid && iss_ready)
		begin
			op_q <= iss_op;
			size_q <= iss_size;
			sign_q <= iss_sign && iss_size == SZ_HALF;
			rev_q <= iss_rev;
			upd_q <= iss_update;
			le_q <= little_endian;
			base_q <= iss_base;
			dest_q <= iss_dest;
			ea_q <= iss_ea;
			src_q <= iss_src_data;
			cross_q <= |mask_d[15:DW_BYTES];
			mask_q <= mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Load assembly from one or two double words
	// Bytes of both portions merged
	always_ff @(posedge clk)
	begin
		if (reset)
			load_q <= '0;
		else if (state_q == LSU_FIRST && dc_ack && !dc_reload)
			load_q <= dc_rdata >> {ea_q[OFS_W-1:0], 3'h0};
		else if (state_q == LSU_SECOND && dc_ack && !dc_reload)
			load_q <= load_q | 64'(dc_rdata
				<< {(4'h8 - {1'b0, ea_q[OFS_W-1:0]}), 3'h0});
		else if (state_q == LSU_BUS && bus_ack)
			load_q <= dc_rdata;
	end

	////////////////////////////////////////////////////////////////////
	// Cache port, one portion per cycle
	always_comb
	begin
		dc_req = state_q == LSU_FIRST || state_q == LSU_SECOND;
		dc_we = op_q == LSU_OP_STORE || op_q == LSU_OP_ECOUT;
		dc_addr = {ea_q[XLEN-1:OFS_W], 3'h0};
		dc_be = mask_q[DW_BYTES-1:0];
		// Store element placed at its bytes
		dc_wdata = merged;
		if (state_q == LSU_SECOND)
		begin
			dc_addr = 32'({ea_q[XLEN-1:OFS_W], 3'h0} + DW_BYTES);
			dc_be = mask_q[15:DW_BYTES];
			dc_wdata = swapped >> {(4'h8 - {1'b0, ea_q[2:0]}), 3'h0};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Gather slot: qualifying word stores wait for a partner
	// Only this slot combines stores
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pend_q <= 1'b0;
			pend_addr_q <= '0;
			pend_data_q <= '0;
		end
		// New store wins over a drain in the same cycle
		else if (iss_valid && iss_ready && gather_ok && !bad_form
			&& !pair_hit && (!pend_q || flush))
		begin
			pend_q <= 1'b1;
			pend_addr_q <= iss_ea;
			pend_data_q <= iss_src_data[31:0];
		end
		else if (flush)
			pend_q <= 1'b0;
	end

	// Gathered partner held until the bus takes the pair
	always_ff @(posedge clk)
	begin
		if (reset)
			gath_q <= 1'b0;
		else if (iss_valid && iss_ready && pair_hit && !bad_form)
			gath_q <= 1'b1;
		else if (flush)
			gath_q <= 1'b0;
	end

	logic [31:0] part_data_q;
	always_ff @(posedge clk)
	begin
		if (reset)
			part_data_q <= '0;
		else if (iss_valid && iss_ready && pair_hit)
			part_data_q <= iss_src_data[31:0];
	end

	////////////////////////////////////////////////////////////////////
	// Bus port: conditional, gathered pair, then instruction fetch
	always_comb
	begin
		bus_req = 1'b0;
		bus_we = 1'b0;
		bus_global = 1'b0;
		bus_addr = '0;
		bus_wdata = '0;
		bus_be = 8'h00;
		if (state_q == LSU_BUS)
		begin
			bus_req = 1'b1;
			bus_we = 1'b1;
			bus_global = 1'b1;
			bus_addr = {ea_q[XLEN-1:OFS_W], 3'h0};
			bus_wdata = merged;
			bus_be = mask_q[DW_BYTES-1:0];
		end
		else if (state_q == LSU_IDLE && pend_q && (gath_q || iss_sync))
		begin
			bus_req = 1'b1;
			bus_we = 1'b1;
			bus_addr = {pend_addr_q[XLEN-1:OFS_W], 3'h0};
			bus_be = pend_addr_q[2] ? 8'hf0 : 8'h0f;
			if (gath_q)
				bus_be = 8'hff;
			bus_wdata = pend_addr_q[2] ? {pend_data_q, part_data_q}
				: {part_data_q, pend_data_q};
			if (!gath_q)
				bus_wdata = {pend_data_q, pend_data_q};
		end
		else if (ifetch_req)
		begin
			bus_req = 1'b1;
			bus_addr = ifetch_addr;
			bus_global = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reservation on an aligned section
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rsv_valid_q <= 1'b0;
			rsv_sect_q <= '0;
		end
		else if (state_q == LSU_DONE && op_q == LSU_OP_LRES)
		begin
			rsv_valid_q <= 1'b1;
			rsv_sect_q <= ea_q[XLEN-1:RSV_SHIFT];
		end
		else if (state_q == LSU_DONE && op_q == LSU_OP_SCOND)
			rsv_valid_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Results, one cycle in the done state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wb_valid <= 1'b0;
			wb_reg <= REG_ZERO;
			wb_data <= '0;
			upd_valid <= 1'b0;
			upd_reg <= REG_ZERO;
			upd_data <= '0;
			cond_ok <= 1'b0;
		end
		else
		begin
			// Same done cycle for every form
			wb_valid <= state_q == LSU_DONE && (op_q == LSU_OP_LOAD
				|| op_q == LSU_OP_LRES);
			wb_reg <= dest_q;
			wb_data <= filled;
			// Update when base valid and, for loads, distinct from destination
			upd_valid <= state_q == LSU_DONE && upd_q && base_q != REG_ZERO
				&& (op_q == LSU_OP_STORE || base_q != dest_q);
			upd_reg <= base_q;
			upd_data <= ea_q;
			cond_ok <= state_q == LSU_DONE && op_q == LSU_OP_SCOND
				&& rsv_valid_q && rsv_sect_q == ea_q[XLEN-1:RSV_SHIFT];
		end
	end

	// Fault, invalid form and restart pulses
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fault_dsi <= 1'b0;
			invalid_form <= 1'b0;
			restart <= 1'b0;
		end
		else
		begin
			// Write-through alone never faults the pair
			fault_dsi <= (state_q == LSU_FIRST || state_q == LSU_SECOND)
				&& (dc_fault || (dc_wt_fault && op_q != LSU_OP_LRES
				&& op_q != LSU_OP_SCOND));
			invalid_form <= iss_valid && iss_ready && bad_form;
			restart <= state_q == LSU_SECOND && dc_fault;
		end
	end
endmodule

//--- tb/lsu_chk_sva.sv
// Port checker for the load/store unit
module lsu_chk
	import lsu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Issue side
	input wire logic iss_valid,
	input wire logic iss_ready,
	input wire lsu_pkg::lsu_op_t iss_op,
	input wire logic [31:0] iss_instr,
	// Cache and bus side
	input wire logic dc_req,
	input wire logic dc_ack,
	input wire logic dc_reload,
	input wire logic [XLEN-1:0] dc_addr,
	input wire logic bus_req,
	input wire logic bus_global,
	input wire logic ifetch_req,
	// Results
	input wire logic wb_valid,
	input wire logic upd_valid,
	input wire logic [REGIDX_W-1:0] upd_reg,
	input wire logic invalid_form,
	input wire logic restart
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Accepted request of one kind
	sequence s_take(lsu_op_t k);
		iss_valid && iss_ready && iss_op == k;
	endsequence
	// Load finishes or restarts
	sequence s_end;
		##[2:60] (wb_valid || restart);
	endsequence
	a_one_op: assert property (s_take(LSU_OP_LOAD) |=> !iss_ready)
		else $error("unit stayed ready after a load");
	a_load_ends: assert property (s_take(LSU_OP_LOAD) |-> s_end)
		else $error("load produced no result");
	a_store_form: assert property (s_take(LSU_OP_STORE) ##0
		iss_instr[RC_BIT] |-> ##[1:3] invalid_form)
		else $error("store with record bit not refused");
	a_base_nonzero: assert property (upd_valid |-> upd_reg != REG_ZERO)
		else $error("base update to register zero");
	a_fetch_plain: assert property (ifetch_req && bus_req |-> !bus_global)
		else $error("fetch marked coherent");
	a_req_holds: assert property (dc_req && !dc_ack |=>
		dc_req && $stable(dc_addr))
		else $error("cache request dropped early");
	a_reload_wait: assert property (dc_req && dc_reload |=> dc_req)
		else $error("request lost during reload");
	a_reload_quiet: assert property (dc_reload |=> !restart[*3])
		else $error("reload caused a restart");
	a_cond_bus: assert property (s_take(LSU_OP_SCOND) |-> ##[1:40] bus_req)
		else $error("conditional store missed the bus");
endmodule
////////////////////////////////////////
bind lsu_core lsu_chk u_chk (.clk, .reset, .iss_valid, .iss_ready, .iss_op,
	.iss_instr, .dc_req, .dc_ack, .dc_reload, .dc_addr, .bus_req,
	.bus_global, .ifetch_req, .wb_valid, .upd_valid, .upd_reg,
	.invalid_form, .restart);

//--- tb/lsu_mem.sv
// Behavioural data cache and system bus partner
module lsu_mem
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Scenario controls
	input wire logic clr,
	input wire logic [3:0] lat,
	input wire logic [1:0] fault_at,
	input wire logic [1:0] reload_at,
	input wire logic [63:0] pat,
	// Cache side
	input wire logic dc_req,
	output logic dc_ack,
	output logic [63:0] dc_rdata,
	output logic dc_reload,
	output logic dc_fault,
	// Bus side
	input wire logic bus_req,
	output logic bus_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] w_q;
	logic [3:0] bw_q;
	logic [1:0] idx_q;
	logic rl;
	// Reload holds the chosen access three cycles
	assign rl = 2'(idx_q + 2'h1) == reload_at;
	assign dc_reload = dc_req && rl && w_q < 4'h3;
	assign dc_ack = dc_req && w_q >= (rl ? 4'h3 : lat);
	assign dc_fault = dc_ack && 2'(idx_q + 2'h1) == fault_at;
	// Data toggles outside the ack so stale lanes never look valid
	assign dc_rdata = dc_ack ? pat : ~pat ^ {16{w_q}};
	assign bus_ack = bus_req && bw_q >= lat;
	// Wait counters
	always_ff @(posedge clk)
	begin
		w_q <= (reset || !dc_req || dc_ack) ? 4'h0 : w_q + 4'h1;
		bw_q <= (reset || !bus_req || bus_ack) ? 4'h0 : bw_q + 4'h1;
	end
	// Access index since the last clear
	always_ff @(posedge clk)
	begin
		if (reset || clr)
			idx_q <= 2'h0;
		else if (dc_ack)
			idx_q <= idx_q + 2'h1;
	end
endmodule

//--- tb/load_store_unit_tb.sv
// Self-checking bench for the load/store unit
module load_store_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lsu_pkg::*;
	logic clk = 0, reset = 1, iss_valid = 0, iss_sign = 0, iss_rev = 0;
	logic iss_update = 0, iss_sync = 0, attr_wt = 0, attr_ci = 0;
	logic attr_guard = 0, little_endian = 0, ifetch_req = 0, clr = 0;
	lsu_op_t iss_op = LSU_OP_LOAD;
	logic [1:0] iss_size = 0, fault_at = 0, reload_at = 0;
	logic [31:0] iss_instr = 0, iss_ea = 0, cfg = 0, ifetch_addr = 0;
	logic [4:0] iss_base = 5'h03, iss_dest = 5'h04, upd_reg, ur;
	logic [63:0] iss_src_data = 64'h0123, dc_rdata, wb_data;
	logic [63:0] pat = 64'h8181818181818181;
	logic [3:0] lat = 4'h1;
	logic iss_ready, dc_req, dc_ack, dc_reload, dc_fault, bus_req, bus_ack;
	logic bus_global, wb_valid, upd_valid, cond_ok, invalid_form, restart;
	logic [31:0] upd_data, wd, ud;
	logic [7:0] bus_be, be_q, g;
	int error_cnt = 0, cmp_count = 0, cyc = 0, t0, t_wb, lat0, i;
	int n_acc, n_bus, n_wb, n_rst, n_inv, n_ok;
	// Gather cases: enable guard reverse little half barrier swap single
	localparam logic [7:0] GT [8] = '{8'h81, 8'h83, 8'h93, 8'h00,
		8'hc0, 8'ha0, 8'h88, 8'h84};
	always #2 clk = ~clk;
	lsu_core DUT (.clk, .reset, .iss_valid, .iss_ready, .iss_op, .iss_size,
		.iss_sign, .iss_rev, .iss_update, .iss_float(1'b0), .iss_instr,
		.iss_base, .iss_dest, .iss_ea, .iss_src_data, .iss_sync, .attr_wt,
		.attr_ci, .attr_guard, .attr_table_walk(1'b0), .little_endian,
		.impl_config_reg_zero(cfg), .dc_req, .dc_we(), .dc_addr(),
		.dc_wdata(), .dc_be(), .dc_ack, .dc_rdata, .dc_reload, .dc_fault,
		.dc_wt_fault(1'b0), .bus_req, .bus_we(), .bus_global, .bus_addr(),
		.bus_wdata(), .bus_be, .bus_ack, .ifetch_req, .ifetch_addr,
		.wb_valid, .wb_reg(), .wb_data, .upd_valid, .upd_reg, .upd_data,
		.cond_ok, .fault_dsi(), .invalid_form, .restart);
	lsu_mem u_mem (.clk, .reset, .clr, .lat, .fault_at, .reload_at, .pat,
		.dc_req, .dc_ack, .dc_rdata, .dc_reload, .dc_fault, .bus_req,
		.bus_ack);
	////////////////////////////////////////
	// Event counters and captured results
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (dc_req && dc_ack && !dc_reload) n_acc <= n_acc + 1;
		if (bus_req && bus_ack) n_bus <= n_bus + 1;
		if (bus_req && bus_ack) be_q <= bus_be;
		if (wb_valid) n_wb <= n_wb + 1;
		if (wb_valid) t_wb <= cyc;
		if (wb_valid) wd <= wb_data[31:0];
		if (upd_valid) {ur, ud} <= {upd_reg, upd_data};
		if (restart) n_rst <= n_rst + 1;
		if (invalid_form) n_inv <= n_inv + 1;
		if (cond_ok) n_ok <= n_ok + 1;
	end
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, a);
		cmp_count++;
		if (e !== a)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, a);
		end
	endtask
	// Counters clear off the edge to avoid racing the monitor
	task automatic clear();
		@(negedge clk);
		{n_acc, n_bus, n_wb, n_rst, n_inv, n_ok} = '0;
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
	endtask
	// Idle means ready for six cycles; a pending pulse lands meanwhile
	task automatic settle();
		int k, run;
		run = 0;
		for (k = 0; k < 300 && run < 6; k++)
		begin
			@(negedge clk);
			run = iss_ready ? run + 1 : 0;
		end
		if (run < 6)
		begin
			error_cnt++;
			final_report();
		end
	endtask
	// Flags: record bit, sign, reverse, update, sync
	task automatic op(input lsu_op_t o, input logic [1:0] sz,
		input logic [31:0] ea, input logic [4:0] f);
		@(posedge clk);
		iss_valid <= 1'b1;
		iss_op <= o;
		iss_size <= sz;
		iss_ea <= ea;
		{iss_instr[RC_BIT], iss_sign, iss_rev, iss_update, iss_sync} <= f;
		@(posedge clk);
		iss_valid <= 1'b0;
		t0 = cyc;
		settle();
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		settle();
		// Fill styles and equal latency
		clear(); op(LSU_OP_LOAD, SZ_BYTE, 32'h1000, 5'h00);
		chk("byte zero", 32'h81, wd);
		lat0 = t_wb - t0;
		clear(); op(LSU_OP_LOAD, SZ_HALF, 32'h1002, 5'h08);
		chk("half sign", 32'hffff8181, wd);
		chk("sign latency", lat0, t_wb - t0);
		clear(); op(LSU_OP_LOAD, SZ_WORD, 32'h1004, 5'h04);
		chk("swap latency", lat0, t_wb - t0);
		clear(); op(LSU_OP_LOAD, SZ_WORD, 32'h2000, 5'h02);
		chk("load update", {5'h03, 32'h2000}, {ur, ud});
		// Crossing access, then a fault and a reload on its second half
		clear(); op(LSU_OP_LOAD, SZ_WORD, 32'h1006, 5'h00);
		chk("split count", 2, n_acc);
		chk("split data", 32'h81818181, wd);
		chk("split slower", 1, t_wb - t0 > lat0);
		fault_at = 2'h2;
		clear(); op(LSU_OP_LOAD, SZ_WORD, 32'h1006, 5'h00);
		chk("restart", 1, n_rst);
		fault_at = 2'h0;
		reload_at = 2'h2;
		clear(); op(LSU_OP_LOAD, SZ_WORD, 32'h1006, 5'h00);
		chk("reload restart", 0, n_rst);
		chk("reload done", 1, n_wb);
		reload_at = 2'h0;
		// Store form, store with update
		clear(); op(LSU_OP_STORE, SZ_WORD, 32'h5000, 5'h10);
		chk("store form", 1, n_inv);
		clear(); op(LSU_OP_STORE, SZ_WORD, 32'h5008, 5'h02);
		chk("store write", 1, n_acc);
		chk("store update", {5'h03, 32'h5008}, {ur, ud});
		// Reservation inside and outside the 32-byte section
		for (i = 0; i < 2; i++)
		begin
			clear(); op(LSU_OP_LRES, SZ_WORD, 32'h4000, 5'h00);
			op(LSU_OP_SCOND, SZ_WORD, i ? 32'h4020 : 32'h401c, 5'h00);
			chk("reserve", i ? 0 : 1, n_ok);
			chk("cond bus", 1, n_bus > 0);
		end
		// Gathering table with a slow partner
		lat = 4'h3;
		for (i = 0; i < 8; i++)
		begin
			g = GT[i];
			@(posedge clk);
			cfg <= {31'h0, g[7]};
			attr_ci <= 1'b1;
			attr_guard <= g[6];
			little_endian <= g[4];
			clear();
			op(LSU_OP_STORE, g[3] ? SZ_HALF : SZ_WORD,
				g[1] ? 32'h3004 : 32'h3000, {2'h0, g[5], 2'h0});
			if (g[2]) op(LSU_OP_BARRIER, SZ_WORD, 32'h0, 5'h01);
			op(LSU_OP_STORE, g[3] ? SZ_HALF : SZ_WORD,
				g[1] ? 32'h3000 : 32'h3004, {2'h0, g[5], 2'h0});
			op(LSU_OP_BARRIER, SZ_WORD, 32'h0, 5'h01);
			chk("gather count", g[0] ? 1 : 2, n_bus + n_acc);
			if (g[0]) chk("gather lanes", 8'hff, be_q);
		end
		// Instruction fetch goes out non-coherent
		@(posedge clk);
		ifetch_addr <= 32'h6000;
		ifetch_req <= 1'b1;
		for (i = 0; i < 100 && !(bus_req && bus_ack); i++) @(negedge clk);
		chk("fetch seen", 1, i < 100);
		chk("fetch global", 0, bus_global);
		@(posedge clk);
		ifetch_req <= 1'b0;
		final_report();
	end
endmodule
